// *** rtl/mwcs_top.sv ***
// Wakeup control and status register bank of the Ethernet MAC, with its event
// latching, resume auto-clear, wake request, frame store decision and interrupt.
// Assumes every input comes from logic on clk_i, and a classic Wishbone master.
`timescale 1ns/100ps
module mwcs_top (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [11:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // MAC status and events.
  input wire logic energy_efficient_enable_i,
  input wire logic deep_frame_storing_suspend_i,
  input wire logic resume_done_i,
  input wire mwcs_pkg::mwcs_evt_s evt_i,
  input wire mwcs_pkg::mwcs_frame_s frame_i,
  // Results.
  output logic wake_req_o,
  output logic frame_keep_o,
  output logic frame_drop_o,
  output logic irq_o
);

  // Stored fields of the wakeup control and status register.
  logic filter_engine_wake_enable;
  logic tx_lpi_exit_wake_flag;
  logic tx_lpi_exit_wake_enable;
  logic rx_lpi_exit_wake_flag;
  logic rx_lpi_exit_wake_enable;
  logic filter_engine_wake_frame_flag;
  logic store_wake_frame;
  logic own_address_frame_flag;
  // Resume control bits.
  logic resume_clears_enables;
  logic resume_clears_flags;
  // Interrupt state.
  logic [mwcs_pkg::MWCS_IRQ_W-1:0] irq_sts;
  logic [mwcs_pkg::MWCS_IRQ_W-1:0] irq_mask;

  // Bus decode: a request is served in the cycle before ack rises.
  wire logic req = cyc_i & stb_i & ~ack_o;
  wire logic wr = req & we_i;
  wire logic [31:0] wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  wire logic [31:0] wdat = dat_i & wmask;
  wire logic hit_wucsr = adr_i == mwcs_pkg::MWCS_ADDR_WAKE_CSR;
  wire logic hit_ctrl = adr_i == mwcs_pkg::MWCS_ADDR_CTRL;
  wire logic hit_sts = adr_i == mwcs_pkg::MWCS_ADDR_IRQ_STS;
  wire logic hit_mask = adr_i == mwcs_pkg::MWCS_ADDR_IRQ_MASK;
  wire logic wr_wucsr = wr & hit_wucsr;
  wire logic wr_ctrl = wr & hit_ctrl;
  wire logic wr_sts = wr & hit_sts;
  wire logic wr_mask = wr & hit_mask;

  // Resume completion strobes for each class of bit.
  wire logic res_clr_en = resume_done_i & resume_clears_enables; // RULE_03
  wire logic res_clr_flag = resume_done_i & resume_clears_flags; // RULE_04

  // Qualified set events; the low-power-idle flags need their enable and EEE.
  wire logic set_tx = evt_i.tx_lpi_exit & tx_lpi_exit_wake_enable & energy_efficient_enable_i; // RULE_05 RULE_06
  wire logic set_rx = evt_i.rx_lpi_exit & rx_lpi_exit_wake_enable & energy_efficient_enable_i; // RULE_09 RULE_10
  wire logic set_fe = evt_i.fe_frame_pass; // RULE_12
  wire logic set_oa = evt_i.own_addr_frame; // RULE_17

  // Write-one-to-clear terms from software, per flag.
  wire logic w1c_tx = wr_wucsr & wdat[mwcs_pkg::MWCS_B_TX_FLAG]; // RULE_18
  wire logic w1c_rx = wr_wucsr & wdat[mwcs_pkg::MWCS_B_RX_FLAG]; // RULE_18
  wire logic w1c_fe = wr_wucsr & wdat[mwcs_pkg::MWCS_B_FE_FLAG]; // RULE_18
  wire logic w1c_oa = wr_wucsr & wdat[mwcs_pkg::MWCS_B_OA_FLAG]; // RULE_18

  // Next flag values: a set in the same cycle as any clear wins, so no event is lost.
  // For the transmit and receive flags the EEE enable overrides everything, as each is held low without it.
  wire logic next_tx_flag = energy_efficient_enable_i &
    (set_tx | (tx_lpi_exit_wake_flag & ~w1c_tx & ~res_clr_flag)); // RULE_07
  wire logic next_rx_flag = energy_efficient_enable_i &
    (set_rx | (rx_lpi_exit_wake_flag & ~w1c_rx & ~res_clr_flag)); // RULE_07
  wire logic next_fe_flag = set_fe | (filter_engine_wake_frame_flag & ~w1c_fe & ~res_clr_flag);
  wire logic next_oa_flag = set_oa | (own_address_frame_flag & ~w1c_oa & ~res_clr_flag);

  // Enable byte lane 1 carries bits 14 down to 8.
  wire logic lane1 = sel_i[1];
  wire logic wr_en_lane = wr_wucsr & lane1;

  // Next enable values; the resume clear wins over a write landing in the same cycle,
  // since the resume sequence marks the end of suspend and enables must be off then.
  wire logic next_fe_en = res_clr_en ? 1'b0 :
    (wr_en_lane ? dat_i[mwcs_pkg::MWCS_B_FE_EN] : filter_engine_wake_enable); // RULE_03
  wire logic next_tx_en = res_clr_en ? 1'b0 :
    (wr_en_lane ? dat_i[mwcs_pkg::MWCS_B_TX_EN] : tx_lpi_exit_wake_enable); // RULE_03
  wire logic next_rx_en = res_clr_en ? 1'b0 :
    (wr_en_lane ? dat_i[mwcs_pkg::MWCS_B_RX_EN] : rx_lpi_exit_wake_enable); // RULE_03
  wire logic next_store = wr_en_lane ? dat_i[mwcs_pkg::MWCS_B_STORE] : store_wake_frame;

  // Wake request sources, each gated by its own enable.
  wire logic wake_fe = evt_i.fe_frame_pass & filter_engine_wake_enable; // RULE_02
  wire logic wake_tx = evt_i.tx_lpi_exit & tx_lpi_exit_wake_enable & energy_efficient_enable_i; // RULE_08
  wire logic wake_rx = evt_i.rx_lpi_exit & rx_lpi_exit_wake_enable & energy_efficient_enable_i; // RULE_11
  wire logic next_wake = wake_fe | wake_tx | wake_rx;

  // Frame store decision. Outside deep suspend the store control is ignored and the
  // waking frame is treated as when the control is clear. A wake that was not a frame
  // never flags a frame as waker, so every later good frame is simply kept.
  wire logic keep_waker = store_wake_frame & deep_frame_storing_suspend_i; // RULE_16
  wire logic keep_this = frame_i.good & (~frame_i.waker | keep_waker); // RULE_13 RULE_14 RULE_15
  wire logic next_keep = frame_i.done & keep_this;
  wire logic next_drop = frame_i.done & ~keep_this;

  // Interrupt status: each event sets its bit, a written one clears it, set wins.
  wire logic [mwcs_pkg::MWCS_IRQ_W-1:0] irq_set = {set_oa, set_fe, set_rx, set_tx};
  wire logic [mwcs_pkg::MWCS_IRQ_W-1:0] irq_clr = wr_sts ? wdat[mwcs_pkg::MWCS_IRQ_W-1:0] :
    mwcs_pkg::MWCS_IRQ_RST;
  wire logic [mwcs_pkg::MWCS_IRQ_W-1:0] next_irq_sts = irq_set | (irq_sts & ~irq_clr);
  wire logic [mwcs_pkg::MWCS_IRQ_W-1:0] next_irq_mask = wr_mask ?
    ((dat_i[mwcs_pkg::MWCS_IRQ_W-1:0] & wmask[mwcs_pkg::MWCS_IRQ_W-1:0]) |
     (irq_mask & ~wmask[mwcs_pkg::MWCS_IRQ_W-1:0])) : irq_mask;
  wire logic next_irq = |(next_irq_sts & next_irq_mask);

  // Read image of each register; reserved bits are zero.
  logic [31:0] rd_wucsr;
  logic [31:0] rd_ctrl;
  logic [31:0] rd_sts;
  logic [31:0] rd_mask;
  always_comb begin
    rd_wucsr = mwcs_pkg::MWCS_ZERO_WORD; // RULE_18
    rd_wucsr[mwcs_pkg::MWCS_B_FE_EN] = filter_engine_wake_enable;
    rd_wucsr[mwcs_pkg::MWCS_B_TX_FLAG] = tx_lpi_exit_wake_flag;
    rd_wucsr[mwcs_pkg::MWCS_B_TX_EN] = tx_lpi_exit_wake_enable;
    rd_wucsr[mwcs_pkg::MWCS_B_RX_FLAG] = rx_lpi_exit_wake_flag;
    rd_wucsr[mwcs_pkg::MWCS_B_RX_EN] = rx_lpi_exit_wake_enable;
    rd_wucsr[mwcs_pkg::MWCS_B_FE_FLAG] = filter_engine_wake_frame_flag;
    rd_wucsr[mwcs_pkg::MWCS_B_STORE] = store_wake_frame;
    rd_wucsr[mwcs_pkg::MWCS_B_OA_FLAG] = own_address_frame_flag;
    rd_ctrl = mwcs_pkg::MWCS_ZERO_WORD;
    rd_ctrl[mwcs_pkg::MWCS_B_CLR_EN] = resume_clears_enables;
    rd_ctrl[mwcs_pkg::MWCS_B_CLR_FLAG] = resume_clears_flags;
    rd_sts = mwcs_pkg::MWCS_ZERO_WORD;
    rd_sts[mwcs_pkg::MWCS_IRQ_W-1:0] = irq_sts;
    rd_mask = mwcs_pkg::MWCS_ZERO_WORD;
    rd_mask[mwcs_pkg::MWCS_IRQ_W-1:0] = irq_mask;
  end

  // Unmapped addresses read as zero and are still acknowledged.
  wire logic [31:0] rd_word = hit_wucsr ? rd_wucsr :
    hit_ctrl ? rd_ctrl :
    hit_sts ? rd_sts :
    hit_mask ? rd_mask : mwcs_pkg::MWCS_ZERO_WORD;
  wire logic [31:0] next_dat = (req & ~we_i) ? rd_word : dat_o;
  wire logic next_ctrl_en = (wr_ctrl & sel_i[0]) ? dat_i[mwcs_pkg::MWCS_B_CLR_EN] : resume_clears_enables;
  wire logic next_ctrl_fl = (wr_ctrl & sel_i[0]) ? dat_i[mwcs_pkg::MWCS_B_CLR_FLAG] : resume_clears_flags;

  // Bus handshake: one wait state, ack for exactly one cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= mwcs_pkg::MWCS_ZERO_WORD;
    end else begin
      ack_o <= req;
      dat_o <= next_dat;
    end
  end

  // Wake flags.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_lpi_exit_wake_flag <= 1'b0;
      rx_lpi_exit_wake_flag <= 1'b0;
      filter_engine_wake_frame_flag <= 1'b0;
      own_address_frame_flag <= 1'b0;
    end else begin
      tx_lpi_exit_wake_flag <= next_tx_flag;
      rx_lpi_exit_wake_flag <= next_rx_flag;
      filter_engine_wake_frame_flag <= next_fe_flag;
      own_address_frame_flag <= next_oa_flag;
    end
  end

  // Wake enables and the store control.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filter_engine_wake_enable <= 1'b0;
      tx_lpi_exit_wake_enable <= 1'b0;
      rx_lpi_exit_wake_enable <= 1'b0;
      store_wake_frame <= 1'b0;
    end else begin
      filter_engine_wake_enable <= next_fe_en;
      tx_lpi_exit_wake_enable <= next_tx_en;
      rx_lpi_exit_wake_enable <= next_rx_en;
      store_wake_frame <= next_store;
    end
  end

  // Resume control bits.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      resume_clears_enables <= 1'b0;
      resume_clears_flags <= 1'b0;
    end else begin
      resume_clears_enables <= next_ctrl_en;
      resume_clears_flags <= next_ctrl_fl;
    end
  end

  // Interrupt status, mask and output.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_sts <= mwcs_pkg::MWCS_IRQ_RST;
      irq_mask <= mwcs_pkg::MWCS_IRQ_RST;
      irq_o <= 1'b0;
    end else begin
      irq_sts <= next_irq_sts;
      irq_mask <= next_irq_mask;
      irq_o <= next_irq;
    end
  end

  // Registered result pulses, one cycle after their cause.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_req_o <= 1'b0;
      frame_keep_o <= 1'b0;
      frame_drop_o <= 1'b0;
    end else begin
      wake_req_o <= next_wake;
      frame_keep_o <= next_keep;
      frame_drop_o <= next_drop;
    end
  end

  // Checks on the logic above.

  // Without EEE the transmit and receive flags must read zero a cycle later.
  a_eee_forces_low: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_07
    !energy_efficient_enable_i |=> !tx_lpi_exit_wake_flag && !rx_lpi_exit_wake_flag)
    else $error("LPI wake flag set while EEE is off");

  // The transmit flag can only rise when its enable was set at the cause.
  a_tx_flag_gated: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_06
    $rose(tx_lpi_exit_wake_flag) |-> $past(tx_lpi_exit_wake_enable) && $past(evt_i.tx_lpi_exit))
    else $error("TX wake flag rose without enable and event");

  // The receive flag can only rise when its enable was set at the cause.
  a_rx_flag_gated: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_10
    $rose(rx_lpi_exit_wake_flag) |-> $past(rx_lpi_exit_wake_enable) && $past(evt_i.rx_lpi_exit))
    else $error("RX wake flag rose without enable and event");

  // An enabled transmit exit with EEE on sets the flag next cycle.
  a_tx_flag_sets: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_05
    evt_i.tx_lpi_exit && tx_lpi_exit_wake_enable && energy_efficient_enable_i
    |=> tx_lpi_exit_wake_flag)
    else $error("TX wake flag missed its event");

  // An enabled receive exit with EEE on sets the flag next cycle.
  a_rx_flag_sets: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_09
    evt_i.rx_lpi_exit && rx_lpi_exit_wake_enable && energy_efficient_enable_i
    |=> rx_lpi_exit_wake_flag)
    else $error("RX wake flag missed its event");

  // A passing frame sets the filter-engine flag, even against a clear.
  a_fe_flag_sets: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_12
    evt_i.fe_frame_pass |=> filter_engine_wake_frame_flag)
    else $error("Filter engine frame flag missed its event");

  // An own-address frame sets its flag next cycle.
  a_oa_flag_sets: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_17
    evt_i.own_addr_frame |=> own_address_frame_flag)
    else $error("Own address flag missed its event");

  // Resume with clear-enables leaves all three enables off.
  a_resume_enables: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_03
    resume_done_i && resume_clears_enables
    |=> !filter_engine_wake_enable && !tx_lpi_exit_wake_enable && !rx_lpi_exit_wake_enable)
    else $error("Enables survived resume clear");

  // Resume with clear-flags drops the frame flags unless a new event arrived.
  a_resume_flags: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_04
    resume_done_i && resume_clears_flags && !evt_i.fe_frame_pass && !evt_i.own_addr_frame
    |=> !filter_engine_wake_frame_flag && !own_address_frame_flag)
    else $error("Frame flags survived resume clear");

  // Writing a zero to the own-address flag bit never clears that flag once set.
  a_zero_write_keeps: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_18
    wr_wucsr && !resume_done_i && own_address_frame_flag && !dat_i[mwcs_pkg::MWCS_B_OA_FLAG]
    |=> own_address_frame_flag)
    else $error("Zero write cleared a flag");

  // An enabled filter-engine frame raises the wake request.
  a_fe_wake_req: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_02
    evt_i.fe_frame_pass && filter_engine_wake_enable |=> wake_req_o)
    else $error("Filter engine wake request missing");

  // An enabled transmit exit raises the wake request.
  a_tx_wake_req: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_08
    evt_i.tx_lpi_exit && tx_lpi_exit_wake_enable && energy_efficient_enable_i |=> wake_req_o)
    else $error("TX exit wake request missing");

  // An enabled receive exit raises the wake request.
  a_rx_wake_req: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_11
    evt_i.rx_lpi_exit && rx_lpi_exit_wake_enable && energy_efficient_enable_i |=> wake_req_o)
    else $error("RX exit wake request missing");

  // In deep suspend with store set, a good waking frame is kept.
  a_store_waker: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_13
    frame_i.done && frame_i.good && frame_i.waker && store_wake_frame && deep_frame_storing_suspend_i
    |=> frame_keep_o && !frame_drop_o)
    else $error("Waking frame not stored");

  // With store clear, or outside deep suspend, the waking frame is dropped.
  a_drop_waker: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_14 RULE_16
    frame_i.done && frame_i.waker && !(store_wake_frame && deep_frame_storing_suspend_i)
    |=> frame_drop_o && !frame_keep_o)
    else $error("Waking frame not dropped");

  // Later good frames are always kept.
  a_keep_later: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_15
    frame_i.done && frame_i.good && !frame_i.waker |=> frame_keep_o)
    else $error("Later good frame not stored");

  // Ack lasts exactly one cycle per request.
  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("Ack held longer than one cycle");

endmodule

// *** pkg/mwcs_pkg.sv ***
// Constants, field layouts and carrier types for the MAC wakeup control/status block.
// Assumes a single MAC clock domain and a classic Wishbone register bus with 32-bit data.
//
// How it works
// RULE_01 - Software keeps all wake enables cleared during normal operation.
// RULE_02 - Filter-engine enable lets passing, non-errored received frames request a wakeup.
// RULE_03 - Resume completion clears enables 14, 12, 10 when resume-clears-enables is set.
// RULE_04 - Resume completion clears flags 13, 11, 9, 7 when resume-clears-flags is set.
// RULE_05 - Transmitter leaving low-power idle on delay-timer expiry sets flag 13.
// RULE_06 - Flag 13 never sets while enable 12 is cleared.
// RULE_07 - Energy-efficient enable low forces flags 13 and 11 to zero.
// RULE_08 - Enable 12 makes a transmitter low-power-idle exit request a wakeup.
// RULE_09 - Receiver leaving low-power idle on partner wake signaling sets flag 11.
// RULE_10 - Flag 11 never sets while enable 10 is cleared.
// RULE_11 - Enable 10 makes received wake signaling request a wakeup.
// RULE_12 - A non-errored frame passing the filter engine sets flag 9.
// RULE_13 - Store control set: waking frame and later good frames go to receive FIFO.
// RULE_14 - Store control cleared: waking frame dropped, later good frames stored.
// RULE_15 - Wake not caused by a frame: all later qualifying frames are stored.
// RULE_16 - Store control acts only in deep frame-storing suspend, otherwise no effect.
// RULE_17 - A valid frame matching our own physical address sets flag 7.
// RULE_18 - Flags clear by writing one; zero leaves them; bits 31 to 15 read zero.
package mwcs_pkg;

  // Register byte addresses on the bus.
  localparam logic [11:0] MWCS_ADDR_WAKE_CSR = 12'h140;
  localparam logic [11:0] MWCS_ADDR_CTRL = 12'h148;
  localparam logic [11:0] MWCS_ADDR_IRQ_STS = 12'h14c;
  localparam logic [11:0] MWCS_ADDR_IRQ_MASK = 12'h150;

  // Field positions in the wakeup control and status register.
  localparam int MWCS_B_FE_EN = 14;
  localparam int MWCS_B_TX_FLAG = 13;
  localparam int MWCS_B_TX_EN = 12;
  localparam int MWCS_B_RX_FLAG = 11;
  localparam int MWCS_B_RX_EN = 10;
  localparam int MWCS_B_FE_FLAG = 9;
  localparam int MWCS_B_STORE = 8;
  localparam int MWCS_B_OA_FLAG = 7;

  // Field positions in the resume control register.
  localparam int MWCS_B_CLR_EN = 0;
  localparam int MWCS_B_CLR_FLAG = 1;

  // Interrupt status and mask layout, one bit per wake event.
  localparam int MWCS_I_TX = 0;
  localparam int MWCS_I_RX = 1;
  localparam int MWCS_I_FE = 2;
  localparam int MWCS_I_OA = 3;
  localparam int MWCS_IRQ_W = 4;

  // Reset values.
  localparam logic [31:0] MWCS_ZERO_WORD = 32'h0000_0000;
  localparam logic [MWCS_IRQ_W-1:0] MWCS_IRQ_RST = 4'h0;

  // Events arriving from the MAC, each a one-cycle pulse.
  typedef struct packed {
    logic tx_lpi_exit;
    logic rx_lpi_exit;
    logic fe_frame_pass;
    logic own_addr_frame;
  } mwcs_evt_s;

  // A received frame at its end, as judged by the MAC and filter engine.
  typedef struct packed {
    logic done;
    logic good;
    logic waker;
  } mwcs_frame_s;

endpackage

// *** tb/mac_wakeup_ctrl_status_tb.sv ***
// Self-checking bench for the MAC wakeup control and status register bank.
// Assumes the design answers every Wishbone request and pulses its results one cycle after an event.
`timescale 1ns/100ps
module mac_wakeup_ctrl_status_tb;
  localparam logic [11:0] A_CSR = mwcs_pkg::MWCS_ADDR_WAKE_CSR;
  localparam logic [11:0] A_CTL = mwcs_pkg::MWCS_ADDR_CTRL;
  localparam logic [11:0] A_STS = mwcs_pkg::MWCS_ADDR_IRQ_STS;
  localparam logic [11:0] A_MSK = mwcs_pkg::MWCS_ADDR_IRQ_MASK;
  localparam logic [11:0] A_BAD = 12'h200;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [11:0] adr_i = 12'h000;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [31:0] dat_o;
  logic ack_o;
  logic ee_i = 1'b0;
  logic deep_i = 1'b0;
  logic resume_i = 1'b0;
  mwcs_pkg::mwcs_evt_s evt_i = '0;
  mwcs_pkg::mwcs_frame_s frame_i = '0;
  logic wake_req_o;
  logic frame_keep_o;
  logic frame_drop_o;
  logic irq_o;
  logic due = 1'b0;
  logic [31:0] rq[$];
  logic [3:0] pq[$];
  int n_mismatch = 0;
  int checks = 0;

  mwcs_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .energy_efficient_enable_i(ee_i),
    .deep_frame_storing_suspend_i(deep_i), .resume_done_i(resume_i), .evt_i(evt_i), .frame_i(frame_i),
    .wake_req_o(wake_req_o), .frame_keep_o(frame_keep_o), .frame_drop_o(frame_drop_o), .irq_o(irq_o));

  // Free-running 50 MHz clock.
  always #10 clk_i = ~clk_i;

  // Prints the verdict once and stops the run.
  task automatic complete_run();
    if (n_mismatch == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // One comparison; four-state equality so an unknown never matches.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One classic Wishbone cycle, held until ack is sampled high, then one idle cycle.
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'hf;
    dat_i <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (ack_o === 1'b1) break;
    end
    if (n == 20) begin
      n_mismatch++;
      complete_run();
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  // The expected read value is noted before the cycle starts.
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask

  // One-cycle event pulse; the expected {wake, keep, drop, irq} is noted for the watcher.
  task automatic pulse(input logic [3:0] e, input logic [2:0] f, input logic r, input logic [3:0] x);
    @(posedge clk_i);
    evt_i <= mwcs_pkg::mwcs_evt_s'(e);
    frame_i <= mwcs_pkg::mwcs_frame_s'(f);
    resume_i <= r;
    due <= 1'b1;
    pq.push_back(x);
    @(posedge clk_i);
    evt_i <= '0;
    frame_i <= '0;
    resume_i <= 1'b0;
    due <= 1'b0;
  endtask

  // Watcher: compares read data at ack and result pulses one cycle after an event, oldest note first.
  always @(posedge clk_i) begin
    logic d;
    d = due;
    #1;
    if (ack_o === 1'b1 && we_i === 1'b0) begin
      if (rq.size() == 0) n_mismatch++;
      else check("read data", dat_o, rq.pop_front());
    end
    if (d) begin
      if (pq.size() == 0) n_mismatch++;
      else check("wake keep drop irq", {28'h0, wake_req_o, frame_keep_o, frame_drop_o, irq_o},
        {28'h0, pq.pop_front()});
    end
  end

  // Hang guard for the whole run.
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    complete_run();
  end

  // Main sequence.
  initial begin
    logic [31:0] w;
    logic st[5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
    logic dp[5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
    logic [2:0] fr[5] = '{3'b111, 3'b111, 3'b110, 3'b111, 3'b100};
    logic [1:0] kd[5] = '{2'b10, 2'b01, 2'b10, 2'b01, 2'b01};
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    void'($urandom(63));
    rd(A_CSR, 32'h0);
    rd(A_CTL, 32'h0);
    rd(A_STS, 32'h0);
    rd(A_MSK, 32'h0);
    wr(A_BAD, 32'hffff_ffff);
    rd(A_BAD, 32'h0);
    w = $urandom;
    wr(A_CSR, w);
    rd(A_CSR, w & 32'h0000_5500);
    wr(A_CSR, 32'h0);
    ee_i <= 1'b1;
    pulse(4'b1000, 3'b000, 1'b0, 4'b0000);
    pulse(4'b0100, 3'b000, 1'b0, 4'b0000);
    rd(A_CSR, 32'h0);
    wr(A_MSK, 32'hf);
    wr(A_CSR, 32'h5500);
    pulse(4'b1000, 3'b000, 1'b0, 4'b1001);
    rd(A_CSR, 32'h7500);
    pulse(4'b0100, 3'b000, 1'b0, 4'b1001);
    rd(A_CSR, 32'h7d00);
    pulse(4'b0010, 3'b000, 1'b0, 4'b1001);
    rd(A_CSR, 32'h7f00);
    pulse(4'b0001, 3'b000, 1'b0, 4'b0001);
    rd(A_CSR, 32'h7f80);
    rd(A_STS, 32'hf);
    wr(A_CSR, 32'h5500);
    rd(A_CSR, 32'h7f80);
    wr(A_CSR, 32'h7500);
    rd(A_CSR, 32'h5f80);
    ee_i <= 1'b0;
    pulse(4'b1000, 3'b000, 1'b0, 4'b0001);
    rd(A_CSR, 32'h5780);
    ee_i <= 1'b1;
    wr(A_STS, 32'hf);
    rd(A_STS, 32'h0);
    wr(A_MSK, 32'h0);
    pulse(4'b0001, 3'b000, 1'b0, 4'b0000);
    rd(A_STS, 32'h8);
    wr(A_MSK, 32'h8);
    // An idle pulse routes the interrupt level through the watcher queue.
    pulse(4'b0000, 3'b000, 1'b0, 4'b0001);
    wr(A_STS, 32'h8);
    pulse(4'b0000, 3'b000, 1'b0, 4'b0000);
    wr(A_MSK, 32'h0);
    // Leftover flags from earlier scenarios would spoil the resume reads, so clear them all first.
    wr(A_CSR, 32'h0000_2a80);
    rd(A_CSR, 32'h0);
    // Every resume-clear setting, with one flag and all enables set beforehand.
    for (int c = 0; c < 4; c++) begin
      wr(A_CTL, 32'(c));
      wr(A_CSR, 32'h5500);
      pulse(4'b0010, 3'b000, 1'b0, 4'b1000);
      pulse(4'b0000, 3'b000, 1'b1, 4'b0000);
      rd(A_CSR, (c[0] ? 32'h0100 : 32'h5500) | (c[1] ? 32'h0 : 32'h0200));
      wr(A_CSR, 32'h0200);
    end
    // Frame store decisions over store control, suspend depth, waker and quality.
    wr(A_CTL, 32'h0);
    for (int i = 0; i < 5; i++) begin
      wr(A_CSR, {23'h0, st[i], 8'h00});
      deep_i <= dp[i];
      pulse(4'b0000, fr[i], 1'b0, {1'b0, kd[i], 1'b0});
    end
    repeat (3) @(posedge clk_i);
    complete_run();
  end
endmodule
